// ---- shared/hts_pkg.sv ----
// constants shared by both ends of the humidity/temperature i2c link
package hts_pkg;
   localparam logic [6:0] DEV_ADDR = 7'h40;
   localparam logic [7:0] CMD_HUM_HOLD = 8'hE5;
   localparam logic [7:0] CMD_HUM_POLL = 8'hF5;
   localparam logic [7:0] CMD_TMP_HOLD = 8'hE3;
   localparam logic [7:0] CMD_TMP_POLL = 8'hF3;
   localparam logic [7:0] CMD_TMP_PREV = 8'hE0;
   localparam logic [7:0] CMD_RESET = 8'hFE;
   localparam logic [7:0] CMD_USER_WR = 8'hE6;
   localparam logic [7:0] CMD_USER_RD = 8'hE7;
   localparam logic [7:0] CMD_HEAT_WR = 8'h51;
   localparam logic [7:0] CMD_HEAT_RD = 8'h11;
   localparam logic [7:0] CMD_IDA_0 = 8'hFA;
   localparam logic [7:0] CMD_IDA_1 = 8'h0F;
   localparam logic [7:0] CMD_IDB_0 = 8'hFC;
   localparam logic [7:0] CMD_IDB_1 = 8'hC9;
   localparam logic [7:0] CMD_FW_0 = 8'h84;
   localparam logic [7:0] CMD_FW_1 = 8'hB8;
   localparam logic [7:0] CRC_POLY = 8'h31;
   localparam logic [7:0] CRC_INIT = 8'h00;
   localparam logic [1:0] HUM_LSB = 2'h2;
   localparam logic [1:0] TMP_LSB = 2'h0;
   localparam logic [7:0] USER_RESET = 8'h00;
   localparam logic [3:0] HEATER_RESET = 4'h0;
   localparam logic [1:0] ROLE_ADDR = 2'h0;
   localparam logic [1:0] ROLE_CMD = 2'h1;
   localparam logic [1:0] ROLE_CMD2 = 2'h2;
   localparam logic [1:0] ROLE_DATA = 2'h3;
   localparam logic [3:0] RS_NONE = 4'h0;
   localparam logic [3:0] RS_HUM = 4'h1;
   localparam logic [3:0] RS_TEMP = 4'h2;
   localparam logic [3:0] RS_PREV = 4'h3;
   localparam logic [3:0] RS_USER = 4'h4;
   localparam logic [3:0] RS_HEAT = 4'h5;
   localparam logic [3:0] RS_IDA = 4'h6;
   localparam logic [3:0] RS_IDB = 4'h7;
   localparam logic [3:0] RS_FW = 4'h8;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_TIME_NS = 12000;
   localparam int CONV_CYCLES_DEF = CONV_TIME_NS / CLK_PERIOD_NS;
   localparam int SCL_PERIOD_NS = 640;
   localparam int SCL_QUARTER = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
      logic [7:0] c;
      c = crc ^ data;
      for (int i = 0; i < 8; i++)
         c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
      return c;
   endfunction : crc8_step
endpackage : hts_pkg

// ---- shared/hts_link_if.sv ----
// open-drain scl/sda link joining the master and the sensor
`timescale 1ns/1ps
`default_nettype none
interface hts_link_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_scl_o;
   logic s_scl_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic scl;
   logic sda;
   // wired-and with pull-up: any enabled low driver wins
   assign scl = !((m_scl_oe && !m_scl_o) || (s_scl_oe && !s_scl_o));
   assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));
   modport sensor (input scl, input sda, output s_scl_o, output s_scl_oe, output s_sda_o, output s_sda_oe);
   modport master (input scl, input sda, output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe);
endinterface : hts_link_if
`default_nettype wire

// ---- verilog/hts_sensor.sv ----
// sensor end: i2c slave, command decode, conversion handshake, crc
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - answer only address 0x40 with r/w
// - E5 humidity stretch, F5 humidity refuse
// - E3 temperature stretch, F3 temperature refuse
// - E0 returns humidity-time temperature, no conversion
// - FE reset, E6/E7 user register access
// - 51 writes heater, 11 reads heater
// - FA0F and FC C9 read identifier halves
// - 84 B8 reads firmware revision
// - host sends only listed command codes
// - stretch style: ack, hold scl low
// - refuse read address while a no-hold conversion runs, retry later
// - checksum only after host acks lsb
// - crc-8 poly 0x31, init 0x00
// - checksum on conversions, identifiers only
// - stop before repeated start accepted
// - humidity word lowest bits are 10
// - temperature word lowest bits are 00
// - humidity conversion also captures temperature
module hts_sensor
   import hts_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYCLES_DEF,
   parameter logic [63:0] SERIAL_ID = 64'h0123_4567_89AB_CDEF, // arbitrary value
   parameter logic [7:0] FW_REV = 8'h5A // arbitrary value
)(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // link pins
   hts_link_if.sensor LINK,
   // conversion engine samples
   input wire logic [15:0] HUM_RAW,
   input wire logic [15:0] TEMP_RAW,
   // settings and status
   output logic [7:0] USER_REG,
   output logic [3:0] HEATER_REG,
   output logic CONV_BUSY
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RX = 6'b000010,
      ST_RXACK = 6'b000100,
      ST_TX = 6'b001000,
      ST_TXACK = 6'b010000,
      ST_HOLD = 6'b100000
   } sst_e;

   sst_e st_q;
   logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic [1:0] role_q;
   logic rd_q, ack_q, sda_oe_q, scl_oe_q;
   logic [7:0] pre_q, user_q, crc_q;
   logic [3:0] heater_q, resp_q;
   logic heat_tgt_q, busy_q, hum_q, hold_q;
   logic [15:0] conv_cnt_q, hum_word_q, temp_word_q, prev_temp_q;
   logic [2:0] di_q;
   logic [1:0] grp_q;

   // edges and bus conditions, only from the second sync stage on
   wire rise_w = scl_s_q && !scl_p_q;
   wire fall_w = !scl_s_q && scl_p_q;
   wire start_w = scl_s_q && scl_p_q && sda_p_q && !sda_s_q;
   wire stop_w = scl_s_q && scl_p_q && !sda_p_q && sda_s_q;
   wire eval_w = (st_q == ST_RX) && fall_w && (cnt_q == 4'd8);

   // byte decode
   wire is_addr = role_q == ROLE_ADDR;
   wire addr_hit = sh_q[7:1] == DEV_ADDR;
   wire rd_bit = sh_q[0];
   wire refuse_w = rd_bit && busy_q && !hold_q;
   wire ack_w = is_addr ? (addr_hit && !refuse_w) : 1'b1;
   wire cmd_ev = eval_w && role_q == ROLE_CMD;
   wire cmd2_ev = eval_w && role_q == ROLE_CMD2;
   wire data_ev = eval_w && role_q == ROLE_DATA;
   wire hum_cmd = sh_q == CMD_HUM_HOLD || sh_q == CMD_HUM_POLL;
   wire tmp_cmd = sh_q == CMD_TMP_HOLD || sh_q == CMD_TMP_POLL;
   wire stretch_cmd = sh_q == CMD_HUM_HOLD || sh_q == CMD_TMP_HOLD;
   wire rst_cmd = sh_q == CMD_RESET;
   wire is_pre = sh_q == CMD_IDA_0 || sh_q == CMD_IDB_0 || sh_q == CMD_FW_0;
   wire is_wr = sh_q == CMD_USER_WR || sh_q == CMD_HEAT_WR;
   wire [1:0] role_nx_w = is_addr ? ROLE_CMD :
                          (role_q == ROLE_CMD && is_pre) ? ROLE_CMD2 :
                          (role_q == ROLE_CMD && is_wr) ? ROLE_DATA : ROLE_CMD;
   wire [3:0] resp_c1_w = hum_cmd ? RS_HUM : tmp_cmd ? RS_TEMP :
                          (sh_q == CMD_TMP_PREV) ? RS_PREV :
                          (sh_q == CMD_USER_RD) ? RS_USER :
                          (sh_q == CMD_HEAT_RD) ? RS_HEAT : RS_NONE;
   wire [3:0] resp_c2_w = (pre_q == CMD_IDA_0 && sh_q == CMD_IDA_1) ? RS_IDA :
                          (pre_q == CMD_IDB_0 && sh_q == CMD_IDB_1) ? RS_IDB :
                          (pre_q == CMD_FW_0 && sh_q == CMD_FW_1) ? RS_FW : RS_NONE;

   // response byte selection
   wire is_word = resp_q == RS_HUM || resp_q == RS_TEMP || resp_q == RS_PREV;
   wire is_id = resp_q == RS_IDA || resp_q == RS_IDB;
   wire [15:0] word_w = (resp_q == RS_HUM) ? hum_word_q : (resp_q == RS_TEMP) ? temp_word_q : prev_temp_q;
   wire [31:0] id_w = (resp_q == RS_IDA) ? SERIAL_ID[63:32] : SERIAL_ID[31:0];
   wire [7:0] id_byte = id_w[(5'd24 - {di_q[1:0], 3'b000}) +: 8];
   wire [7:0] one_byte = (resp_q == RS_USER) ? user_q : (resp_q == RS_HEAT) ? {4'h0, heater_q} : FW_REV;
   wire [7:0] data_w = is_word ? (di_q[0] ? word_w[7:0] : word_w[15:8]) : is_id ? id_byte : one_byte;
   wire [2:0] len_w = is_word ? 3'd2 : is_id ? 3'd4 : (resp_q == RS_NONE) ? 3'd0 : 3'd1;
   wire [1:0] every_w = (resp_q == RS_HUM || resp_q == RS_TEMP || resp_q == RS_IDB) ? 2'd2 :
                        (resp_q == RS_IDA) ? 2'd1 : 2'd0;
   wire crc_due = every_w != 2'd0 && grp_q == every_w;
   wire more_w = di_q < len_w;
   // past the end the line is simply released (0xFF)
   wire [7:0] next_byte = crc_due ? crc_q : more_w ? data_w : 8'hFF;
   wire hold_w = busy_q && hold_q;
   wire load_w = (st_q == ST_RXACK && fall_w && ack_q && rd_q && !hold_w) ||
                 (st_q == ST_HOLD && !busy_q) ||
                 (st_q == ST_TXACK && fall_w && ack_q);

   assign LINK.s_scl_o = 1'b0;
   assign LINK.s_sda_o = 1'b0;
   assign LINK.s_scl_oe = scl_oe_q;
   assign LINK.s_sda_oe = sda_oe_q;
   assign USER_REG = user_q;
   assign HEATER_REG = heater_q;
   assign CONV_BUSY = busy_q;

   // two-stage sync plus one stage for edge finding
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
         {sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
      end
      else
      begin
         {scl_m_q, scl_s_q, scl_p_q} <= {LINK.scl, scl_m_q, scl_s_q};
         {sda_m_q, sda_s_q, sda_p_q} <= {LINK.sda, sda_m_q, sda_s_q};
      end
   end

   // link state machine; sda only changes after an scl fall was seen
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         role_q <= ROLE_ADDR;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end
      else if (start_w)
      begin
         st_q <= ST_RX;
         role_q <= ROLE_ADDR;
         cnt_q <= 4'h0;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end
      else if (stop_w)
      begin
         st_q <= ST_IDLE;
         sda_oe_q <= 1'b0;
         scl_oe_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            ST_RX:
            begin
               if (rise_w)
               begin
                  sh_q <= {sh_q[6:0], sda_s_q};
                  cnt_q <= cnt_q + 4'd1;
               end
               else if (eval_w)
               begin
                  sda_oe_q <= ack_w;
                  ack_q <= ack_w;
                  rd_q <= is_addr && rd_bit;
                  role_q <= role_nx_w;
                  cnt_q <= 4'h0;
                  st_q <= ST_RXACK;
               end
            end
            ST_RXACK:
            begin
               if (fall_w)
               begin
                  if (!ack_q)
                  begin
                     sda_oe_q <= 1'b0;
                     st_q <= ST_IDLE;
                  end
                  else if (rd_q && hold_w)
                  begin
                     sda_oe_q <= 1'b0;
                     scl_oe_q <= 1'b1;
                     st_q <= ST_HOLD;
                  end
                  else if (rd_q)
                  begin
                     sh_q <= next_byte;
                     sda_oe_q <= !next_byte[7];
                     st_q <= ST_TX;
                  end
                  else
                  begin
                     sda_oe_q <= 1'b0;
                     st_q <= ST_RX;
                  end
               end
            end
            ST_HOLD:
            begin
               if (!busy_q)
               begin
                  // scl stays low one more cycle so sda settles before it rises
                  sh_q <= next_byte;
                  sda_oe_q <= !next_byte[7];
                  cnt_q <= 4'h0;
                  st_q <= ST_TX;
               end
            end
            ST_TX:
            begin
               scl_oe_q <= 1'b0;
               if (rise_w)
                  cnt_q <= cnt_q + 4'd1;
               else if (fall_w && cnt_q == 4'd8)
               begin
                  sda_oe_q <= 1'b0;
                  st_q <= ST_TXACK;
               end
               else if (fall_w)
               begin
                  sh_q <= {sh_q[6:0], 1'b1};
                  sda_oe_q <= !sh_q[6];
               end
            end
            ST_TXACK:
            begin
               if (rise_w)
                  ack_q <= !sda_s_q;
               else if (fall_w && ack_q)
               begin
                  sh_q <= next_byte;
                  sda_oe_q <= !next_byte[7];
                  cnt_q <= 4'h0;
                  st_q <= ST_TX;
               end
               else if (fall_w)
                  st_q <= ST_IDLE;
            end
            default:
               st_q <= st_q;
         endcase
      end
   end

   // commands, settings and the conversion handshake
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || (cmd_ev && rst_cmd))
      begin
         busy_q <= 1'b0;
         user_q <= USER_RESET;
         heater_q <= HEATER_RESET;
         resp_q <= RS_NONE;
         conv_cnt_q <= 16'h0000;
         hum_q <= 1'b0;
         hold_q <= 1'b0;
         pre_q <= 8'h00;
         heat_tgt_q <= 1'b0;
         if (SYS_RST)
         begin
            hum_word_q <= {14'h0000, HUM_LSB};
            temp_word_q <= {14'h0000, TMP_LSB};
            prev_temp_q <= {14'h0000, TMP_LSB};
         end
      end
      else
      begin
         if (cmd_ev)
         begin
            resp_q <= resp_c1_w;
            pre_q <= sh_q;
            heat_tgt_q <= sh_q == CMD_HEAT_WR;
         end
         if (cmd2_ev)
            resp_q <= resp_c2_w;
         if (data_ev && heat_tgt_q)
            heater_q <= sh_q[3:0];
         if (data_ev && !heat_tgt_q)
            user_q <= sh_q;
         if (cmd_ev && (hum_cmd || tmp_cmd))
         begin
            busy_q <= 1'b1;
            conv_cnt_q <= 16'(CONV_CYCLES - 1);
            hum_q <= hum_cmd;
            hold_q <= stretch_cmd;
         end
         else if (busy_q && conv_cnt_q != 16'h0000)
            conv_cnt_q <= conv_cnt_q - 16'd1;
         else if (busy_q)
         begin
            busy_q <= 1'b0;
            if (hum_q)
            begin
               hum_word_q <= {HUM_RAW[15:2], HUM_LSB};
               prev_temp_q <= {TEMP_RAW[15:2], TMP_LSB};
            end
            else
               temp_word_q <= {TEMP_RAW[15:2], TMP_LSB};
         end
      end
   end

   // response pointer and running checksum
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || (eval_w && is_addr))
      begin
         di_q <= 3'd0;
         grp_q <= 2'd0;
         crc_q <= CRC_INIT;
      end
      else if (load_w && crc_due)
         grp_q <= 2'd0;
      else if (load_w && more_w)
      begin
         crc_q <= crc8_step(crc_q, data_w);
         di_q <= di_q + 3'd1;
         grp_q <= grp_q + 2'd1;
      end
   end
endmodule : hts_sensor
`default_nettype wire

// ---- verilog/hts_master.sv ----
// master end: generates scl, runs one write/read transaction per request
`timescale 1ns/1ps
`default_nettype none
module hts_master
   import hts_pkg::*;
#(
   parameter int QUARTER = SCL_QUARTER
)(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // link pins
   hts_link_if.master LINK,
   // request
   input wire logic GO,
   input wire logic [1:0] WR_LEN,
   input wire logic [23:0] WR_DATA,
   input wire logic [3:0] RD_LEN,
   input wire logic STOP_SR,
   // answer
   output logic BUSY,
   output logic DONE,
   output logic ADDR_NACK,
   output logic [63:0] RD_DATA
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BYTE = 4'b0100,
      H_STOP = 4'b1000
   } hst_e;

   hst_e st_q;
   logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
   logic [7:0] div_q;
   logic [1:0] q_q;
   logic [3:0] bit_q, rcnt_q;
   logic [7:0] tx_q;
   logic [23:0] wbuf_q;
   logic [1:0] wcnt_q;
   logic rx_q, first_q, rdph_q, restart_q, ack_q, scl_oe_q, sda_oe_q;

   wire tick_w = div_q == 8'(QUARTER - 1);
   // a held-low scl freezes the high quarter: clock stretching
   wire step_w = tick_w && !(q_q == 2'd2 && !scl_s_q);
   wire bit_end = step_w && st_q == H_BYTE && q_q == 2'd3 && bit_q == 4'd8;

   assign LINK.m_scl_o = 1'b0;
   assign LINK.m_sda_o = 1'b0;
   assign LINK.m_scl_oe = scl_oe_q;
   assign LINK.m_sda_oe = sda_oe_q;

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hF;
         div_q <= 8'h00;
      end
      else
      begin
         {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= {LINK.scl, scl_m_q, LINK.sda, sda_m_q};
         div_q <= tick_w ? 8'h00 : div_q + 8'd1;
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         st_q <= H_IDLE;
         {BUSY, DONE, ADDR_NACK, scl_oe_q, sda_oe_q} <= 5'h00;
         {rx_q, first_q, rdph_q, restart_q, ack_q} <= 5'h00;
         RD_DATA <= 64'h0;
         q_q <= 2'd0;
         bit_q <= 4'h0;
         tx_q <= 8'h00;
         wbuf_q <= 24'h0;
         wcnt_q <= 2'd0;
         rcnt_q <= 4'h0;
      end
      else if (st_q == H_IDLE)
      begin
         DONE <= 1'b0;
         if (GO)
         begin
            st_q <= H_START;
            BUSY <= 1'b1;
            ADDR_NACK <= 1'b0;
            RD_DATA <= 64'h0;
            q_q <= 2'd0;
            wbuf_q <= WR_DATA;
            wcnt_q <= WR_LEN;
            rcnt_q <= RD_LEN;
            rdph_q <= WR_LEN == 2'd0;
            restart_q <= 1'b0;
         end
      end
      else if (step_w)
      begin
         q_q <= q_q + 2'd1;
         case (st_q)
            H_START:
            begin
               if (q_q == 2'd0)
                  sda_oe_q <= 1'b0;
               if (q_q == 2'd1)
                  scl_oe_q <= 1'b0;
               if (q_q == 2'd2)
                  sda_oe_q <= 1'b1;
               if (q_q == 2'd3)
               begin
                  scl_oe_q <= 1'b1;
                  st_q <= H_BYTE;
                  bit_q <= 4'h0;
                  rx_q <= 1'b0;
                  first_q <= 1'b1;
                  tx_q <= {DEV_ADDR, rdph_q};
               end
            end
            H_BYTE:
            begin
               if (q_q == 2'd0)
                  sda_oe_q <= rx_q ? (bit_q == 4'd8 && rcnt_q > 4'd1) : (bit_q != 4'd8 && !tx_q[7]);
               if (q_q == 2'd1)
                  scl_oe_q <= 1'b0;
               if (q_q == 2'd2 && rx_q && bit_q != 4'd8)
                  RD_DATA <= {RD_DATA[62:0], sda_s_q};
               if (q_q == 2'd2 && !rx_q && bit_q == 4'd8)
                  ack_q <= !sda_s_q;
               if (q_q == 2'd3)
               begin
                  scl_oe_q <= 1'b1;
                  bit_q <= bit_end ? 4'h0 : bit_q + 4'd1;
                  tx_q <= {tx_q[6:0], 1'b1};
               end
               if (bit_end && !rx_q && !ack_q)
               begin
                  // nacked byte: stop; only a refused read address polls again
                  restart_q <= first_q && rdph_q;
                  ADDR_NACK <= first_q && !rdph_q;
                  st_q <= H_STOP;
               end
               else if (bit_end && !rx_q && !rdph_q && wcnt_q != 2'd0)
               begin
                  tx_q <= wbuf_q[23:16];
                  wbuf_q <= {wbuf_q[15:0], 8'h00};
                  wcnt_q <= wcnt_q - 2'd1;
                  first_q <= 1'b0;
               end
               else if (bit_end && !rx_q && !rdph_q && rcnt_q != 4'h0)
               begin
                  rdph_q <= 1'b1;
                  restart_q <= STOP_SR;
                  st_q <= STOP_SR ? H_STOP : H_START;
               end
               else if (bit_end && !rx_q && rdph_q && rcnt_q != 4'h0)
               begin
                  rx_q <= 1'b1;
                  first_q <= 1'b0;
               end
               else if (bit_end && rx_q && rcnt_q > 4'd1)
                  rcnt_q <= rcnt_q - 4'd1;
               else if (bit_end)
                  st_q <= H_STOP;
            end
            H_STOP:
            begin
               if (q_q == 2'd0)
                  sda_oe_q <= 1'b1;
               if (q_q == 2'd1)
                  scl_oe_q <= 1'b0;
               if (q_q == 2'd2)
                  sda_oe_q <= 1'b0;
               if (q_q == 2'd3)
               begin
                  restart_q <= 1'b0;
                  st_q <= restart_q ? H_START : H_IDLE;
                  DONE <= !restart_q;
                  BUSY <= restart_q;
               end
            end
            default:
               st_q <= H_IDLE;
         endcase
      end
   end
endmodule : hts_master
`default_nettype wire

// ---- sim/hts_link_checker.sv ----
// checker on the scl/sda wires between master and sensor
`timescale 1ns/1ps
`default_nettype none
module hts_link_checker #(
   parameter int CONV_CYCLES = 300
)(
   // clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // driver controls
   input wire logic m_scl_oe,
   input wire logic s_scl_o,
   input wire logic s_scl_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   // resolved lines
   input wire logic scl,
   input wire logic sda
);
   int hold_q;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // stretch length counter; a stuck hold would hang the bus silently
   always_ff @(posedge CLK)
   begin
      if (SYS_RST || !s_scl_oe)
         hold_q <= 0;
      else
         hold_q <= hold_q + 1;
   end
   chk_stretch_bound: assert property (hold_q <= CONV_CYCLES + 32)
      else $error("scl held too long");
   chk_stretch_low: assert property ($rose(s_scl_oe) |-> !scl && m_scl_oe)
      else $error("stretch began with scl high");
   chk_stretch_release: assert property ($fell(s_scl_oe) |-> ##[0:2] scl)
      else $error("scl stuck after stretch");
   chk_sda_scl_low: assert property ($changed(s_sda_oe) && !$past(SYS_RST) |-> !scl)
      else $error("sensor moved sda with scl high");
   chk_idle_after_stop: assert property (scl && $rose(sda) |=> (!s_sda_oe && !s_scl_oe) [*3])
      else $error("sensor drives after stop");
   chk_scl_high_min: assert property ($rose(scl) |-> scl [*3])
      else $error("scl high too short");
   chk_scl_low_min: assert property ($fell(scl) |-> !scl [*4])
      else $error("scl low too short");
   chk_open_drain: assert property ((s_sda_oe |-> !s_sda_o) and (s_scl_oe |-> !s_scl_o))
      else $error("sensor drives a high level");
   cover property ($rose(s_scl_oe));
   cover property (scl && $fell(sda));
   cover property (scl && $rose(sda));
endmodule : hts_link_checker
`default_nettype wire

// ---- sim/humidity_temp_i2c_slave_tb.sv ----
// bench: master and sensor joined over the link, judged at the user side
`timescale 1ns/1ps
`default_nettype none
module humidity_temp_i2c_slave_tb
   import hts_pkg::*;
   ;
   localparam logic [63:0] SID = 64'h0123_4567_89AB_CDEF; // arbitrary value
   localparam int CONV = 600;
   logic clk = 1'b0, sys_rst = 1'b1, go = 1'b0, stop_sr = 1'b0, busy, done, addr_nack, conv_busy;
   logic [1:0] wr_len = 2'h0;
   logic [23:0] wr_data = 24'h0;
   logic [3:0] rd_len = 4'h0, heater_reg;
   logic [15:0] hum_raw = 16'h0, temp_raw = 16'h0;
   logic [63:0] rd_data;
   logic [7:0] user_reg;
   int n_errors = 0, checks = 0;
   always #20 clk = ~clk;
   hts_link_if hts_link_if_i ();
   hts_sensor #(.CONV_CYCLES(CONV), .SERIAL_ID(SID), .FW_REV(8'h5A)) hts_sensor_i (.CLK(clk), .SYS_RST(sys_rst),
      .LINK(hts_link_if_i.sensor), .HUM_RAW(hum_raw), .TEMP_RAW(temp_raw), .USER_REG(user_reg),
      .HEATER_REG(heater_reg), .CONV_BUSY(conv_busy));
   hts_master #(.QUARTER(4)) hts_master_i (.CLK(clk), .SYS_RST(sys_rst), .LINK(hts_link_if_i.master),
      .GO(go), .WR_LEN(wr_len), .WR_DATA(wr_data), .RD_LEN(rd_len), .STOP_SR(stop_sr), .BUSY(busy),
      .DONE(done), .ADDR_NACK(addr_nack), .RD_DATA(rd_data));
   hts_link_checker #(.CONV_CYCLES(CONV)) hts_link_checker_i (.CLK(clk), .SYS_RST(sys_rst),
      .m_scl_oe(hts_link_if_i.m_scl_oe), .s_scl_o(hts_link_if_i.s_scl_o), .s_scl_oe(hts_link_if_i.s_scl_oe),
      .s_sda_o(hts_link_if_i.s_sda_o), .s_sda_oe(hts_link_if_i.s_sda_oe), .scl(hts_link_if_i.scl),
      .sda(hts_link_if_i.sda));
   // own crc so a shared slip in the step function cannot hide
   function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
      logic [7:0] r;
      r = c ^ d;
      for (int i = 0; i < 8; i++)
         r = r[7] ? ({r[6:0], 1'b0} ^ 8'h31) : {r[6:0], 1'b0};
      return r;
   endfunction : crc
   task automatic finish_test();
      if (n_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask : cmp
   task automatic xfer(input logic [1:0] wl, input logic [23:0] wd, input logic [3:0] rl, input logic sr);
      int n;
      @(posedge clk);
      #1;
      go = 1'b1;
      wr_len = wl;
      wr_data = wd;
      rd_len = rl;
      stop_sr = sr;
      @(posedge clk);
      #1;
      go = 1'b0;
      for (n = 0; n < 20000 && done !== 1'b1; n++)
      begin
         @(posedge clk);
         #1;
      end
      if (n == 20000)
      begin
         n_errors++;
         finish_test();
      end
   endtask : xfer
   task automatic conv_all();
      logic [7:0] cm [4] = '{CMD_HUM_HOLD, CMD_HUM_POLL, CMD_TMP_HOLD, CMD_TMP_POLL};
      logic [15:0] w;
      for (int k = 0; k < 4; k++)
      begin
         hum_raw = {4'(k), 12'hC71};
         temp_raw = {12'h6E3, 4'(k)};
         w = (k < 2) ? {hum_raw[15:2], 2'h2} : {temp_raw[15:2], 2'h0};
         xfer(2'h1, {cm[k], 16'h0}, 4'h3, k[0]);
         cmp(rd_data, {40'h0, w, crc(crc(8'h00, w[15:8]), w[7:0])});
      end
   endtask : conv_all
   task automatic prev_temp();
      temp_raw = 16'h9ABF;
      xfer(2'h1, {CMD_HUM_HOLD, 16'h0}, 4'h2, 1'b0);
      cmp(rd_data, {48'h0, hum_raw[15:2], 2'h2});
      temp_raw = 16'h1234;
      xfer(2'h1, {CMD_TMP_PREV, 16'h0}, 4'h3, 1'b0);
      cmp(rd_data, 64'h9ABCFF);
      xfer(2'h0, 24'h0, 4'h2, 1'b0);
      cmp(rd_data, 64'h9ABC);
   endtask : prev_temp
   task automatic regs();
      xfer(2'h2, {CMD_USER_WR, 8'h3A, 8'h00}, 4'h0, 1'b0);
      xfer(2'h1, {CMD_USER_RD, 16'h0}, 4'h2, 1'b0);
      cmp({user_reg, rd_data[15:0]}, 24'h3A3AFF);
      xfer(2'h2, {CMD_HEAT_WR, 8'hF7, 8'h00}, 4'h0, 1'b0);
      xfer(2'h1, {CMD_HEAT_RD, 16'h0}, 4'h1, 1'b0);
      cmp({heater_reg, rd_data[3:0]}, 8'h77);
      xfer(2'h1, {CMD_HUM_POLL, 16'h0}, 4'h0, 1'b0);
      cmp(conv_busy, 1'b1);
      xfer(2'h1, {CMD_RESET, 16'h0}, 4'h0, 1'b0);
      cmp({conv_busy, user_reg, heater_reg}, 13'h0);
   endtask : regs
   task automatic ids();
      logic [7:0] c1, c2, c3, c4, d1, d2;
      c1 = crc(8'h00, SID[63:56]);
      c2 = crc(c1, SID[55:48]);
      c3 = crc(c2, SID[47:40]);
      c4 = crc(c3, SID[39:32]);
      d1 = crc(crc(8'h00, SID[31:24]), SID[23:16]);
      d2 = crc(crc(d1, SID[15:8]), SID[7:0]);
      xfer(2'h2, {CMD_IDA_0, CMD_IDA_1, 8'h00}, 4'h8, 1'b0);
      cmp(rd_data, {SID[63:56], c1, SID[55:48], c2, SID[47:40], c3, SID[39:32], c4});
      xfer(2'h2, {CMD_IDB_0, CMD_IDB_1, 8'h00}, 4'h6, 1'b1);
      cmp(rd_data, {16'h0, SID[31:16], d1, SID[15:0], d2});
      xfer(2'h2, {CMD_FW_0, CMD_FW_1, 8'h00}, 4'h2, 1'b0);
      cmp(rd_data, 64'h5AFF);
   endtask : ids
   initial
   begin
      repeat (6) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      cmp({user_reg, heater_reg, conv_busy, busy, done}, 15'h0);
      conv_all();
      prev_temp();
      regs();
      ids();
      cmp(addr_nack, 1'b0);
      finish_test();
   end
endmodule : humidity_temp_i2c_slave_tb
`default_nettype wire
